/* File: rtl/cavq_defines.svh */
// cavq_defines.svh: constants of the camera adapter output side
// assumes inclusion by bare name from the rtl files
`ifndef CAVQ_DEFINES_SVH
`define CAVQ_DEFINES_SVH

// ============================================================
// video ports
`define CAVQ_NUM_PORTS 4
`define CAVQ_PIX_W 16
`define CAVQ_LINE_W 16

// ============================================================
// write dma
`define CAVQ_WRITE_FIFO_SIZE_LOG2_LOG2 9
`define CAVQ_CHAN_W 3
`define CAVQ_LUMA_LSB 0
`define CAVQ_CHROMA_LSB 8
`define CAVQ_PLANE_LUMA 1'b0
`define CAVQ_PLANE_CHROMA 1'b1

// ============================================================
// urgency codes
`define CAVQ_URG_W 2
`define CAVQ_THR_W 8
`define CAVQ_URG_SAFE 2'h0
`define CAVQ_URG_MID 2'h1
`define CAVQ_URG_HIGH 2'h3

`endif

/* File: rtl/cavq_pkg.sv */
// cavq_pkg: types of the camera adapter output side
// assumes cavq_defines.svh on the include path
`include "cavq_defines.svh"

package cavq_pkg;
    typedef logic [`CAVQ_PIX_W-1:0] cavq_pix_t;
    typedef logic [`CAVQ_NUM_PORTS-1:0][`CAVQ_PIX_W-1:0] cavq_vp_data_t;
    typedef logic [`CAVQ_NUM_PORTS-1:0][`CAVQ_LINE_W-1:0] cavq_lines_t;
    typedef logic [1:0] cavq_vc_t;
    typedef enum {CAVQ_IDLE, CAVQ_ACTIVE} cavq_frm_e;
endpackage : cavq_pkg

/* File: rtl/cavq_line_gate.sv */
// cavq_line_gate: per-context line counter and frame truncation gate
// assumes frame and line pulses on the same clock as clk
`timescale 1ns/1ps
`default_nettype none

module cavq_line_gate #(
    parameter int LW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // frame events of this context
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic line_end,
    input wire logic [LW-1:0] line_limit,
    // gate results
    output logic line_pass,
    output logic frame_short,
    output logic [LW-1:0] lines_done
);
    import cavq_pkg::*;

    cavq_frm_e state_q;
    cavq_frm_e state_d;
    logic [LW-1:0] lines_q;
    logic [LW-1:0] lines_d;
    logic short_q;
    logic below_limit;

    // ============================================================
    // gate decode
    assign below_limit = (lines_q < line_limit);
    assign line_pass = (state_q == CAVQ_ACTIVE) && below_limit;
    assign frame_short = short_q;
    assign lines_done = lines_q;

    always_comb begin
        state_d = state_q;
        lines_d = lines_q;
        case (state_q)
            CAVQ_IDLE: begin
                if (frame_start) begin
                    state_d = CAVQ_ACTIVE;
                    lines_d = '0;
                end
            end
            CAVQ_ACTIVE: begin
                if (frame_start) begin
                    lines_d = '0;
                end else if (frame_end) begin
                    state_d = CAVQ_IDLE;
                end else if (line_end && below_limit) begin
                    lines_d = lines_q + LW'(1);
                end
            end
            default: state_d = CAVQ_IDLE;
        endcase
    end

    // ============================================================
    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CAVQ_IDLE;
            lines_q <= '0;
            short_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lines_q <= lines_d;
            short_q <= (state_q == CAVQ_ACTIVE) && frame_end
                && below_limit;
        end
    end
endmodule : cavq_line_gate

`default_nettype wire

/* File: rtl/cavq_top.sv */
// cavq_top: camera adapter output side - video ports, write dma split,
// frame line gating and urgency generation
// assumes capture stream on CLK_SYS; video port clock and legacy strap
// arrive from outside the CLK_SYS domain
`include "cavq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cavq_top #(
    parameter int NPORT = `CAVQ_NUM_PORTS,
    parameter int WRITE_FIFO_SIZE_LOG2_LOG2 = `CAVQ_WRITE_FIFO_SIZE_LOG2_LOG2
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // mode control
    input wire logic LEGACY_MODE,
    input wire logic [NPORT-1:0] BIPLANAR_MODE,
    input wire cavq_pkg::cavq_lines_t LINE_COUNT,
    // capture stream from the lane interface
    input wire logic CAP_VALID,
    input wire cavq_pkg::cavq_pix_t CAP_DATA,
    input wire cavq_pkg::cavq_vc_t CAP_VC,
    input wire logic CAP_FS,
    input wire logic CAP_LE,
    input wire logic CAP_FE,
    // write dma
    input wire logic WR_READY,
    output logic WR_LUMA_VALID,
    output logic [`CAVQ_CHAN_W-1:0] WR_LUMA_CHAN,
    output cavq_pkg::cavq_pix_t WR_LUMA_DATA,
    output logic WR_CHROMA_VALID,
    output logic [`CAVQ_CHAN_W-1:0] WR_CHROMA_CHAN,
    output cavq_pkg::cavq_pix_t WR_CHROMA_DATA,
    output logic WR_FRAME_END,
    output logic WR_FRAME_DROP,
    output cavq_pkg::cavq_vc_t WR_FRAME_CTX,
    // urgency
    input wire logic WR_REALTIME,
    input wire logic [`CAVQ_THR_W-1:0] WR_SLOTS_READY,
    input wire logic [`CAVQ_THR_W-1:0] URG_LOW_THRESH,
    input wire logic [`CAVQ_THR_W-1:0] URG_HIGH_THRESH,
    output logic [`CAVQ_URG_W-1:0] URGENCY,
    // video output ports
    input wire logic VIDEO_PORT_CLOCK,
    output logic [NPORT-1:0] VP_ENABLE,
    output logic [NPORT-1:0] VP_VALID,
    output logic [NPORT-1:0] VP_FS,
    output logic [NPORT-1:0] VP_LE,
    output cavq_pkg::cavq_vp_data_t VP_DATA,
    // status
    output logic [NPORT-1:0] FRAME_CORRUPT
);
    import cavq_pkg::*;

    // ============================================================
    // synchronisers for legacy strap and video port clock
    logic legacy_s1_q;
    logic legacy_s2_q;
    logic vpclk_s1_q;
    logic vpclk_s2_q;
    logic vpclk_s3_q;
    logic vp_edge;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            legacy_s1_q <= 1'b0;
            legacy_s2_q <= 1'b0;
            vpclk_s1_q <= 1'b0;
            vpclk_s2_q <= 1'b0;
            vpclk_s3_q <= 1'b0;
        end else begin
            legacy_s1_q <= LEGACY_MODE;
            legacy_s2_q <= legacy_s1_q;
            vpclk_s1_q <= VIDEO_PORT_CLOCK;
            vpclk_s2_q <= vpclk_s1_q;
            vpclk_s3_q <= vpclk_s2_q;
        end
    end

    assign vp_edge = vpclk_s2_q && !vpclk_s3_q;

    // ============================================================
    // context decode and line gating
    logic [NPORT-1:0] ctx_sel;
    logic [NPORT-1:0] ctx_pass;
    logic [NPORT-1:0] ctx_short;
    logic [NPORT-1:0] pix_ok;
    logic [NPORT-1:0] drop_evt;

    genvar c;
    generate
        for (c = 0; c < NPORT; c++) begin : g_ctx
            assign ctx_sel[c] = (CAP_VC == cavq_vc_t'(c));
            cavq_line_gate #(
                .LW(`CAVQ_LINE_W)
            ) u_gate (
                .clk(CLK_SYS),
                .rst_n(RESET_N),
                .frame_start(CAP_FS && ctx_sel[c]),
                .frame_end(CAP_FE && ctx_sel[c]),
                .line_end(CAP_LE && ctx_sel[c]),
                .line_limit(LINE_COUNT[c]),
                .line_pass(ctx_pass[c]),
                .frame_short(ctx_short[c]),
                .lines_done()
            );
            assign pix_ok[c] = CAP_VALID && ctx_sel[c] && ctx_pass[c];
        end
    endgenerate

    // ============================================================
    // bi-planar pairing per context
    logic [NPORT-1:0] half_q;
    cavq_pix_t hold_q [NPORT];
    logic any_pix;
    logic cur_bp;
    logic cur_half;
    cavq_pix_t cur_hold;
    logic wr_fire;
    logic wr_lost;
    logic [`CAVQ_CHAN_W-1:0] chan_luma;
    logic [`CAVQ_CHAN_W-1:0] chan_chroma;
    logic [`CAVQ_CHAN_W-1:0] chan_plain;
    cavq_pix_t luma_word;
    cavq_pix_t chroma_word;

    assign any_pix = |pix_ok;
    assign cur_bp = BIPLANAR_MODE[CAP_VC];
    assign cur_half = half_q[CAP_VC];
    assign cur_hold = hold_q[CAP_VC];
    // two dma channels per bi-planar stream, one otherwise; eight for four contexts
    assign chan_luma = {CAP_VC, `CAVQ_PLANE_LUMA};
    assign chan_chroma = {CAP_VC, `CAVQ_PLANE_CHROMA};
    assign chan_plain = {1'b0, CAP_VC};
    assign luma_word = {CAP_DATA[`CAVQ_LUMA_LSB+:8],
        cur_hold[`CAVQ_LUMA_LSB+:8]};
    assign chroma_word = {CAP_DATA[`CAVQ_CHROMA_LSB+:8],
        cur_hold[`CAVQ_CHROMA_LSB+:8]};
    assign wr_fire = any_pix && (!cur_bp || cur_half);
    assign wr_lost = wr_fire && !WR_READY;

    generate
        for (c = 0; c < NPORT; c++) begin : g_pair
            always_ff @(posedge CLK_SYS or negedge RESET_N) begin
                if (!RESET_N) begin
                    half_q[c] <= 1'b0;
                    hold_q[c] <= '0;
                end else if (CAP_FS && ctx_sel[c]) begin
                    half_q[c] <= 1'b0;
                end else if (pix_ok[c] && BIPLANAR_MODE[c]) begin
                    half_q[c] <= !half_q[c];
                    hold_q[c] <= CAP_DATA;
                end
            end
        end
    endgenerate

    // ============================================================
    // write dma outputs
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            WR_LUMA_VALID <= 1'b0;
            WR_LUMA_CHAN <= '0;
            WR_LUMA_DATA <= '0;
            WR_CHROMA_VALID <= 1'b0;
            WR_CHROMA_CHAN <= '0;
            WR_CHROMA_DATA <= '0;
        end else begin
            WR_LUMA_VALID <= wr_fire && WR_READY;
            WR_CHROMA_VALID <= wr_fire && WR_READY && cur_bp;
            if (wr_fire) begin
                WR_LUMA_CHAN <= cur_bp ? chan_luma : chan_plain;
                WR_LUMA_DATA <= cur_bp ? luma_word : CAP_DATA;
                WR_CHROMA_CHAN <= chan_chroma;
                WR_CHROMA_DATA <= chroma_word;
            end
        end
    end

    // frame close: a short frame is handed to the dma as a discard
    logic [NPORT-1:0] fe_q;
    logic fe_any;
    logic [1:0] fe_ctx;

    assign fe_any = |fe_q;
    always_comb begin
        fe_ctx = 2'h0;
        for (int i = 0; i < NPORT; i++) begin
            if (fe_q[i]) begin
                fe_ctx = 2'(i);
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            fe_q <= '0;
            WR_FRAME_END <= 1'b0;
            WR_FRAME_DROP <= 1'b0;
            WR_FRAME_CTX <= '0;
        end else begin
            fe_q <= CAP_FE ? ctx_sel : '0;
            WR_FRAME_END <= fe_any;
            WR_FRAME_DROP <= |(fe_q & (ctx_short | FRAME_CORRUPT));
            if (fe_any) begin
                WR_FRAME_CTX <= fe_ctx;
            end
        end
    end

    // ============================================================
    // video output ports, one hold stage each
    logic [NPORT-1:0] port_on;
    logic [NPORT-1:0] port_beat;
    logic [NPORT-1:0] port_fs_in;
    logic [NPORT-1:0] pend_q;
    logic [NPORT-1:0] pend_fs_q;
    logic [NPORT-1:0] pend_le_q;
    logic [NPORT-1:0] first_q;
    logic [NPORT-1:0] vp_lost;
    cavq_pix_t pend_data_q [NPORT];

    generate
        for (c = 0; c < NPORT; c++) begin : g_port
            if (c == 0) begin : g_first
                assign port_on[c] = 1'b1;
                // legacy forwards every context to the first port
                assign port_beat[c] = legacy_s2_q ? any_pix
                    : pix_ok[c];
                assign port_fs_in[c] = legacy_s2_q ? CAP_FS
                    : CAP_FS && ctx_sel[c];
            end else begin : g_rep
                assign port_on[c] = !legacy_s2_q;
                // port n fixed to capture context n
                assign port_beat[c] = port_on[c] && pix_ok[c];
                assign port_fs_in[c] = CAP_FS && ctx_sel[c];
            end
            assign vp_lost[c] = port_beat[c] && pend_q[c]
                && !vp_edge;

            always_ff @(posedge CLK_SYS or negedge RESET_N) begin
                if (!RESET_N) begin
                    first_q[c] <= 1'b0;
                end else if (port_fs_in[c]) begin
                    first_q[c] <= 1'b1;
                end else if (port_beat[c]) begin
                    first_q[c] <= 1'b0;
                end
            end

            always_ff @(posedge CLK_SYS or negedge RESET_N) begin
                if (!RESET_N) begin
                    pend_q[c] <= 1'b0;
                    pend_fs_q[c] <= 1'b0;
                    pend_le_q[c] <= 1'b0;
                    pend_data_q[c] <= '0;
                end else if (port_beat[c]) begin
                    pend_q[c] <= 1'b1;
                    pend_fs_q[c] <= first_q[c];
                    pend_le_q[c] <= CAP_LE;
                    pend_data_q[c] <= CAP_DATA;
                end else if (vp_edge) begin
                    pend_q[c] <= 1'b0;
                end
            end

            // same settings drive all ports, outputs move on port clock
            always_ff @(posedge CLK_SYS or negedge RESET_N) begin
                if (!RESET_N) begin
                    VP_ENABLE[c] <= 1'b0;
                    VP_VALID[c] <= 1'b0;
                    VP_FS[c] <= 1'b0;
                    VP_LE[c] <= 1'b0;
                    VP_DATA[c] <= '0;
                end else if (vp_edge) begin
                    VP_ENABLE[c] <= port_on[c];
                    VP_VALID[c] <= pend_q[c] && port_on[c];
                    VP_FS[c] <= pend_fs_q[c] && pend_q[c];
                    VP_LE[c] <= pend_le_q[c] && pend_q[c];
                    VP_DATA[c] <= pend_data_q[c];
                end
            end
        end
    endgenerate

    // ============================================================
    // corrupted frame flags, set wins over the frame start clear
    logic [NPORT-1:0] corrupt_set;
    logic [NPORT-1:0] corrupt_clr;

    generate
        for (c = 0; c < NPORT; c++) begin : g_bad
            assign corrupt_set[c] = (wr_lost && ctx_sel[c])
                || vp_lost[c];
            assign corrupt_clr[c] = CAP_FS && ctx_sel[c];
            always_ff @(posedge CLK_SYS or negedge RESET_N) begin
                if (!RESET_N) begin
                    FRAME_CORRUPT[c] <= 1'b0;
                end else if (corrupt_set[c]) begin
                    FRAME_CORRUPT[c] <= 1'b1;
                end else if (corrupt_clr[c]) begin
                    FRAME_CORRUPT[c] <= 1'b0;
                end
            end
        end
    endgenerate

    // ============================================================
    // urgency from write dma ready slots
    logic at_low;
    logic at_high;
    logic [`CAVQ_URG_W-1:0] urg_d;

    assign at_low = (WR_SLOTS_READY >= URG_LOW_THRESH);
    assign at_high = (WR_SLOTS_READY >= URG_HIGH_THRESH);
    assign urg_d = !WR_REALTIME ? `CAVQ_URG_SAFE
        : at_high ? `CAVQ_URG_HIGH
        : at_low ? `CAVQ_URG_MID
        : `CAVQ_URG_SAFE;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            URGENCY <= `CAVQ_URG_SAFE;
        end else begin
            URGENCY <= urg_d;
        end
    end
endmodule : cavq_top

`default_nettype wire

/* File: bench/cavq_top_asserts.sv */
// cavq_top_asserts: port-level checks of cavq_top
// assumes bind onto cavq_top, one clock domain CLK_SYS
`include "cavq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cavq_top_asserts #(
    parameter int NPORT = 4
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // mode and capture
    input wire logic LEGACY_MODE,
    input wire logic [NPORT-1:0] BIPLANAR_MODE,
    input wire logic CAP_VALID,
    input wire cavq_pkg::cavq_pix_t CAP_DATA,
    input wire cavq_pkg::cavq_vc_t CAP_VC,
    input wire logic CAP_FE,
    // write dma
    input wire logic WR_READY,
    input wire logic WR_LUMA_VALID,
    input wire logic [`CAVQ_CHAN_W-1:0] WR_LUMA_CHAN,
    input wire cavq_pkg::cavq_pix_t WR_LUMA_DATA,
    input wire logic WR_CHROMA_VALID,
    input wire logic [`CAVQ_CHAN_W-1:0] WR_CHROMA_CHAN,
    input wire logic WR_FRAME_END,
    input wire logic WR_FRAME_DROP,
    input wire cavq_pkg::cavq_vc_t WR_FRAME_CTX,
    // urgency
    input wire logic WR_REALTIME,
    input wire logic [`CAVQ_THR_W-1:0] WR_SLOTS_READY,
    input wire logic [`CAVQ_THR_W-1:0] URG_LOW_THRESH,
    input wire logic [`CAVQ_THR_W-1:0] URG_HIGH_THRESH,
    input wire logic [`CAVQ_URG_W-1:0] URGENCY,
    // video ports
    input wire logic [NPORT-1:0] VP_ENABLE
);
    import cavq_pkg::*;
    // ============================================================
    // legacy hold counter
    logic [4:0] leg_cnt_q;
    logic [4:0] leg_cnt_d;
    assign leg_cnt_d = !LEGACY_MODE ? 5'h00 :
        (leg_cnt_q == 5'h1F) ? leg_cnt_q : leg_cnt_q + 5'h01;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            leg_cnt_q <= 5'h00;
        end else begin
            leg_cnt_q <= leg_cnt_d;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    // ============================================================
    // properties
    property p_urg_high;
        WR_REALTIME && WR_SLOTS_READY >= URG_HIGH_THRESH |=> URGENCY == 2'h3;
    endproperty
    a_urg_high: assert property (p_urg_high) else $error("not 11");
    property p_urg_mid;
        WR_REALTIME && WR_SLOTS_READY >= URG_LOW_THRESH
            && WR_SLOTS_READY < URG_HIGH_THRESH |=> URGENCY == 2'h1;
    endproperty
    a_urg_mid: assert property (p_urg_mid) else $error("not 01");
    property p_urg_safe;
        (!WR_REALTIME || (WR_SLOTS_READY < URG_LOW_THRESH
            && WR_SLOTS_READY < URG_HIGH_THRESH)) |=> URGENCY == 2'h0;
    endproperty
    a_urg_safe: assert property (p_urg_safe) else $error("not 00");
    property p_legacy;
        leg_cnt_q == 5'h1F && $changed(VP_ENABLE) |-> VP_ENABLE == NPORT'(1);
    endproperty
    a_legacy: assert property (p_legacy) else $error("extra port");
    property p_plain_word;
        CAP_VALID && !BIPLANAR_MODE[CAP_VC] ##1 WR_LUMA_VALID |->
            WR_LUMA_DATA == $past(CAP_DATA)
            && WR_LUMA_CHAN == {1'b0, $past(CAP_VC)};
    endproperty
    a_plain_word: assert property (p_plain_word) else $error("plain");
    property p_no_chroma;
        CAP_VALID && !BIPLANAR_MODE[CAP_VC] |=> !WR_CHROMA_VALID;
    endproperty
    a_no_chroma: assert property (p_no_chroma) else $error("chroma");
    property p_bp_pair;
        WR_CHROMA_VALID |-> WR_LUMA_VALID && WR_CHROMA_CHAN[0]
            && WR_LUMA_CHAN == {WR_CHROMA_CHAN[2:1], 1'b0};
    endproperty
    a_bp_pair: assert property (p_bp_pair) else $error("planes");
    property p_word_cause;
        WR_LUMA_VALID |-> $past(CAP_VALID) && $past(WR_READY);
    endproperty
    a_word_cause: assert property (p_word_cause) else $error("bad");
    property p_frame_end;
        CAP_FE |-> ##2 WR_FRAME_END && WR_FRAME_CTX == $past(CAP_VC, 2);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("no end");
    c_drop: cover property (WR_FRAME_DROP);
    c_chroma: cover property (WR_CHROMA_VALID);
    c_mid: cover property (URGENCY == 2'h1);
endmodule : cavq_top_asserts

bind cavq_top cavq_top_asserts #(.NPORT(NPORT)) i_cavq_top_asserts (
    .CLK_SYS, .RESET_N, .LEGACY_MODE, .BIPLANAR_MODE, .CAP_VALID,
    .CAP_DATA, .CAP_VC, .CAP_FE, .WR_READY, .WR_LUMA_VALID, .WR_LUMA_CHAN,
    .WR_LUMA_DATA, .WR_CHROMA_VALID, .WR_CHROMA_CHAN, .WR_FRAME_END,
    .WR_FRAME_DROP, .WR_FRAME_CTX, .WR_REALTIME, .WR_SLOTS_READY,
    .URG_LOW_THRESH, .URG_HIGH_THRESH, .URGENCY, .VP_ENABLE);
`default_nettype wire

/* File: bench/cavq_cam_model.sv */
// cavq_cam_model: lane-side frame source and video port clock source
// assumes the bench calls send_frame and makes the system clock
`timescale 1ns/1ps
`default_nettype none

module cavq_cam_model (
    // clock
    input wire logic clk,
    // capture stream
    output logic cap_valid,
    output cavq_pkg::cavq_pix_t cap_data,
    output cavq_pkg::cavq_vc_t cap_vc,
    output logic cap_fs,
    output logic cap_le,
    output logic cap_fe,
    // video port clock
    output logic video_port_clock
);
    import cavq_pkg::*;
    logic vp_run = 1'b0;
    // ============================================================
    // port clock, 80 ns, still between frames
    initial begin
        {cap_valid, cap_fs, cap_le, cap_fe, cap_vc} = '0;
        cap_data = 16'h0000;
        video_port_clock = 1'b0;
        #7;
        forever begin
            #40;
            video_port_clock = vp_run ? !video_port_clock : 1'b0;
        end
    end
    // ============================================================
    // frame: start, lines of two pixels, end
    task automatic send_frame(input cavq_vc_t vc, input int lines);
        vp_run = 1'b1;
        @(posedge clk);
        cap_vc <= vc;
        cap_fs <= 1'b1;
        @(posedge clk);
        cap_fs <= 1'b0;
        for (int l = 0; l < lines; l++) begin
            for (int p = 0; p < 2; p++) begin
                repeat (9) @(posedge clk);
                cap_valid <= 1'b1;
                cap_data <= {2'h0, vc, 4'(l), 8'(p)};
                cap_le <= (p == 1);
                @(posedge clk);
                cap_valid <= 1'b0;
                cap_le <= 1'b0;
                cap_data <= ~cap_data;
            end
        end
        repeat (9) @(posedge clk);
        cap_fe <= 1'b1;
        @(posedge clk);
        cap_fe <= 1'b0;
        repeat (20) @(posedge clk);
        vp_run = 1'b0;
    endtask : send_frame
endmodule : cavq_cam_model
`default_nettype wire

/* File: bench/testbench.sv */
// testbench: self-checking bench of cavq_top
// assumes 100 MHz system clock and the camera model as far side
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import cavq_pkg::*;
    typedef struct packed {
        logic rt;
        logic [7:0] n;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [1:0] urg;
    } cavq_urg_row_s;
    logic clk_sys, reset_n, legacy_mode, cap_valid, cap_fs, cap_le, cap_fe;
    logic wr_ready, wr_luma_valid, wr_chroma_valid, wr_frame_end;
    logic wr_frame_drop, wr_realtime, video_port_clock, drop_q;
    logic [3:0] biplanar_mode, vp_enable, vp_valid, vp_fs, vp_le;
    logic [3:0] frame_corrupt, vp_fs_q, vp_le_q;
    logic [2:0] wr_luma_chan, wr_chroma_chan;
    logic [7:0] wr_slots_ready, urg_low_thresh, urg_high_thresh, chan_seen;
    logic [1:0] urgency;
    cavq_lines_t line_count;
    cavq_pix_t cap_data, wr_luma_data, wr_chroma_data, last_l, last_c;
    cavq_vc_t cap_vc, wr_frame_ctx;
    cavq_vp_data_t vp_data;
    int bad_count = 0;
    int n_compared = 0;
    int luma_n, chroma_n, fe_n;
    int fs_n [4], le_n [4], vv_n [4];
    // recommended, equal and extreme thresholds
    cavq_urg_row_s rows [10] = '{
        '{1'b1, 8'h0F, 8'h10, 8'h30, 2'h0}, '{1'b1, 8'h10, 8'h10, 8'h30, 2'h1},
        '{1'b1, 8'h2F, 8'h10, 8'h30, 2'h1}, '{1'b1, 8'h30, 8'h10, 8'h30, 2'h3},
        '{1'b1, 8'hFF, 8'h10, 8'h30, 2'h3}, '{1'b0, 8'h30, 8'h10, 8'h30, 2'h0},
        '{1'b1, 8'h1F, 8'h20, 8'h20, 2'h0}, '{1'b1, 8'h20, 8'h20, 8'h20, 2'h3},
        '{1'b1, 8'h00, 8'h00, 8'h00, 2'h3}, '{1'b1, 8'hFF, 8'hFF, 8'hFF, 2'h3}};

    cavq_top i_cavq_top (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .LEGACY_MODE(legacy_mode),
        .BIPLANAR_MODE(biplanar_mode), .LINE_COUNT(line_count),
        .CAP_VALID(cap_valid), .CAP_DATA(cap_data), .CAP_VC(cap_vc),
        .CAP_FS(cap_fs), .CAP_LE(cap_le), .CAP_FE(cap_fe),
        .WR_READY(wr_ready), .WR_LUMA_VALID(wr_luma_valid),
        .WR_LUMA_CHAN(wr_luma_chan), .WR_LUMA_DATA(wr_luma_data),
        .WR_CHROMA_VALID(wr_chroma_valid), .WR_CHROMA_CHAN(wr_chroma_chan),
        .WR_CHROMA_DATA(wr_chroma_data), .WR_FRAME_END(wr_frame_end),
        .WR_FRAME_DROP(wr_frame_drop), .WR_FRAME_CTX(wr_frame_ctx),
        .WR_REALTIME(wr_realtime), .WR_SLOTS_READY(wr_slots_ready),
        .URG_LOW_THRESH(urg_low_thresh), .URG_HIGH_THRESH(urg_high_thresh),
        .URGENCY(urgency), .VIDEO_PORT_CLOCK(video_port_clock), .VP_ENABLE(vp_enable),
        .VP_VALID(vp_valid), .VP_FS(vp_fs), .VP_LE(vp_le), .VP_DATA(vp_data),
        .FRAME_CORRUPT(frame_corrupt));
    cavq_cam_model i_cavq_cam_model (
        .clk(clk_sys), .cap_valid(cap_valid), .cap_data(cap_data),
        .cap_vc(cap_vc), .cap_fs(cap_fs), .cap_le(cap_le), .cap_fe(cap_fe),
        .video_port_clock(video_port_clock));

    // ============================================================
    // clock, monitor and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (wr_luma_valid === 1'b1) begin
            luma_n++;
            last_l = wr_luma_data;
            chan_seen[wr_luma_chan] = 1'b1;
        end
        if (wr_chroma_valid === 1'b1) begin
            chroma_n++;
            last_c = wr_chroma_data;
            chan_seen[wr_chroma_chan] = 1'b1;
        end
        if (wr_frame_end === 1'b1) begin
            fe_n++;
            drop_q = wr_frame_drop;
        end
        for (int p = 0; p < 4; p++) begin
            if (vp_fs[p] === 1'b1 && vp_fs_q[p] !== 1'b1) fs_n[p]++;
            if (vp_le[p] === 1'b1 && vp_le_q[p] !== 1'b1) le_n[p]++;
            if (vp_valid[p] === 1'b1) vv_n[p]++;
        end
        vp_fs_q = vp_fs;
        vp_le_q = vp_le;
    end
    // about 1,340 cycles of tests; over twenty times that is a hang
    initial begin
        #300000;
        bad_count++;
        tally_and_finish();
    end

    // ============================================================
    // tasks
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h",
                $time, got, exp);
        end
    endtask : check
    task automatic frame(input cavq_vc_t vc, input int lines);
        luma_n = 0;
        chroma_n = 0;
        fe_n = 0;
        fs_n = '{default: 0};
        le_n = fs_n;
        vv_n = fs_n;
        i_cavq_cam_model.send_frame(vc, lines);
        #1;
    endtask : frame
    task automatic tally_and_finish;
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ============================================================
    // main sequence
    initial begin
        {reset_n, legacy_mode, wr_realtime, drop_q} = '0;
        {biplanar_mode, vp_fs_q, vp_le_q, wr_slots_ready, chan_seen} = '0;
        {urg_low_thresh, urg_high_thresh} = '0;
        wr_ready = 1'b1;
        line_count = {4{16'h0004}};
        repeat (20) @(posedge clk_sys);
        #1;
        check({urgency, wr_luma_valid, wr_frame_end, vp_enable}, 0);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        foreach (rows[i]) begin
            @(posedge clk_sys);
            {wr_realtime, wr_slots_ready, urg_low_thresh, urg_high_thresh}
                <= rows[i][26:2];
            @(posedge clk_sys);
            #1;
            check(urgency, rows[i].urg);
        end
        frame(2'h0, 4);
        check({luma_n, 1'b0, drop_q}, {32'd8, 2'h0});
        frame(2'h1, 3);
        check({fe_n, 1'b0, drop_q}, {32'd1, 2'h1});
        frame(2'h2, 6);
        check({luma_n, last_l}, {32'd8, 16'h2301});
        check(vp_data[2], 16'h2301);
        check({le_n[2], vv_n[2]}, {32'd4, 32'd64});
        frame(2'h3, 4);
        check({fe_n, 1'b0, drop_q}, {32'd1, 2'h0});
        check({fs_n[3], fs_n[0]}, {32'd1, 32'd0});
        check(vp_enable, 4'hF);
        @(posedge clk_sys);
        biplanar_mode <= 4'hF;
        for (int v = 0; v < 4; v++) begin
            frame(2'(v), 4);
            check({chroma_n, luma_n}, {32'd4, 32'd4});
        end
        check({last_l, last_c}, {16'h0100, 16'h3333});
        check(chan_seen, 8'hFF);
        @(posedge clk_sys);
        {biplanar_mode, wr_ready} <= 5'h00;
        frame(2'h0, 4);
        check({luma_n, drop_q, frame_corrupt}, {32'd0, 5'h11});
        @(posedge clk_sys);
        wr_ready <= 1'b1;
        frame(2'h0, 4);
        check({luma_n, drop_q, frame_corrupt}, {32'd8, 5'h00});
        @(posedge clk_sys);
        legacy_mode <= 1'b1;
        repeat (40) @(posedge clk_sys);
        frame(2'h2, 4);
        check({fs_n[0], fs_n[2]}, {32'd1, 32'd0});
        check(vp_enable, 4'h1);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
